// ---- tmci_defines.svh ----
/*
  Constants of the 8-bit timer/counter block: register indices, field
  positions, reset values, counter limits, prescaler masks, bus answers.
  Assumes inclusion by bare name from the package and the design module.
*/
`ifndef TMCI_DEFINES_SVH
`define TMCI_DEFINES_SVH

// register indices; byte address is four times the index
`define TMCI_IDX_CTRL_A      8'h2A
`define TMCI_IDX_CTRL_B      8'h33
`define TMCI_IDX_FLAGS       8'h38
`define TMCI_IDX_MASK        8'h39
`define TMCI_IDX_COUNTER     8'h20
`define TMCI_IDX_CMP_A       8'h21
`define TMCI_IDX_CMP_B       8'h22

`define TMCI_ADDR_W          10
`define TMCI_RESET_8         8'h00

// control A fields
`define TMCI_CA_ACT_A_HI     7
`define TMCI_CA_ACT_A_LO     6
`define TMCI_CA_ACT_B_HI     5
`define TMCI_CA_ACT_B_LO     4
`define TMCI_CA_WGM_HI       1
`define TMCI_CA_WGM_LO       0
// control B fields
`define TMCI_CB_FORCE_A      7
`define TMCI_CB_FORCE_B      6
`define TMCI_CB_WGM_HIGH     3
`define TMCI_CB_CS_HI        2
`define TMCI_CB_CS_LO        0
// mask and flag bit positions
`define TMCI_BIT_MATCH_A     4
`define TMCI_BIT_MATCH_B     3
`define TMCI_BIT_OVERFLOW    1

// counter limits
`define TMCI_MAX             8'hFF
`define TMCI_BOTTOM          8'h00
`define TMCI_ONE             8'h01

// prescaler, free running
`define TMCI_PRE_W           10
`define TMCI_PRE_DIV8        10'h007
`define TMCI_PRE_DIV64       10'h03F
`define TMCI_PRE_DIV256      10'h0FF
`define TMCI_PRE_DIV1024     10'h3FF

// bus answers
`define TMCI_RESP_OKAY       2'h0
`define TMCI_RESP_SLVERR     2'h2

`endif

// ---- tmci_pkg.sv ----
/*
  Types of the 8-bit timer/counter block: waveform modes, clock selects,
  register select, and the packed state of the design module.
  Assumes tmci_defines.svh is on the include path.
*/
`include "tmci_defines.svh"

package tmci_pkg;

  typedef enum logic [2:0] {
    TMCI_WGM_NORMAL  = 3'h0,
    TMCI_WGM_PC_FF   = 3'h1,
    TMCI_WGM_CTC     = 3'h2,
    TMCI_WGM_FAST_FF = 3'h3,
    TMCI_WGM_RSV4    = 3'h4,
    TMCI_WGM_PC_OCR  = 3'h5,
    TMCI_WGM_RSV6    = 3'h6,
    TMCI_WGM_FAST_OCR= 3'h7
  } tmci_wgm_e;

  typedef enum logic [2:0] {
    TMCI_CS_STOP     = 3'h0,
    TMCI_CS_DIV1     = 3'h1,
    TMCI_CS_DIV8     = 3'h2,
    TMCI_CS_DIV64    = 3'h3,
    TMCI_CS_DIV256   = 3'h4,
    TMCI_CS_DIV1024  = 3'h5,
    TMCI_CS_EXT_FALL = 3'h6,
    TMCI_CS_EXT_RISE = 3'h7
  } tmci_cs_e;

  typedef enum logic [2:0] {
    TMCI_REG_NONE    = 3'h0,
    TMCI_REG_CTRL_A  = 3'h1,
    TMCI_REG_CTRL_B  = 3'h2,
    TMCI_REG_FLAGS   = 3'h3,
    TMCI_REG_MASK    = 3'h4,
    TMCI_REG_COUNTER = 3'h5,
    TMCI_REG_CMP_A   = 3'h6,
    TMCI_REG_CMP_B   = 3'h7
  } tmci_reg_e;

  typedef struct packed {
    logic [7:0]              ctrl_a;
    logic                    wgm_high;
    logic [2:0]              cs;
    logic [2:0]              mask;       // {a, b, overflow}
    logic [2:0]              flags;      // {a, b, overflow}
    logic [7:0]              cnt;
    logic [7:0]              cmp_a_buf;
    logic [7:0]              cmp_b_buf;
    logic [7:0]              cmp_a;
    logic [7:0]              cmp_b;
    logic                    down;
    logic                    block;
    logic [`TMCI_PRE_W-1:0]  pre;
    logic                    ext_s1;
    logic                    ext_s2;
    logic                    ext_s3;
    logic                    out_a;
    logic                    out_b;
    logic                    con_a;
    logic                    con_b;
    logic [2:0]              irq;        // {a, b, overflow}
    logic                    aw_held;
    logic                    w_held;
    logic [`TMCI_ADDR_W-1:0] waddr;
    logic [7:0]              wdata;
    logic                    wlane0;
    logic                    awready;
    logic                    wready;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    arready;
    logic                    rvalid;
    logic [1:0]              rresp;
    logic [31:0]             rdata;
  } tmci_state_s;

endpackage : tmci_pkg

// ---- tmci_timer0.sv ----
/*
  8-bit timer/counter with normal, clear-on-match, fast and phase-correct
  PWM modes, two compare channels, prescaled or external-pin clocking,
  and match/overflow flags with masked interrupt requests.
  Assumes an AXI4-Lite master on aclk, an asynchronous count pin, and a
  core that pulses the vector acknowledge inputs on the same clock.
*/
`timescale 1ns/1ps
`include "tmci_defines.svh"

module tmci_timer0 (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`TMCI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`TMCI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    ext_count_pin,
  input  wire logic                    global_irq_en,
  input  wire logic                    ack_match_a,
  input  wire logic                    ack_match_b,
  input  wire logic                    ack_overflow,
  output logic                         wave_out_a,
  output logic                         wave_out_b,
  output logic                         wave_out_a_connected,
  output logic                         wave_out_b_connected,
  output logic                         irq_match_a,
  output logic                         irq_match_b,
  output logic                         irq_overflow
);

  tmci_pkg::tmci_state_s st_r;
  tmci_pkg::tmci_state_s st_nxt;

  // address to register; misaligned or unmapped gives none
  function automatic tmci_pkg::tmci_reg_e reg_sel(input logic [`TMCI_ADDR_W-1:0] a);
    logic [7:0] idx;
    idx = a[`TMCI_ADDR_W-1:2];
    if (a[1:0] != 2'h0) begin
      reg_sel = tmci_pkg::TMCI_REG_NONE;
    end else if (idx == `TMCI_IDX_CTRL_A) begin
      reg_sel = tmci_pkg::TMCI_REG_CTRL_A;
    end else if (idx == `TMCI_IDX_CTRL_B) begin
      reg_sel = tmci_pkg::TMCI_REG_CTRL_B;
    end else if (idx == `TMCI_IDX_FLAGS) begin
      reg_sel = tmci_pkg::TMCI_REG_FLAGS;
    end else if (idx == `TMCI_IDX_MASK) begin
      reg_sel = tmci_pkg::TMCI_REG_MASK;
    end else if (idx == `TMCI_IDX_COUNTER) begin
      reg_sel = tmci_pkg::TMCI_REG_COUNTER;
    end else if (idx == `TMCI_IDX_CMP_A) begin
      reg_sel = tmci_pkg::TMCI_REG_CMP_A;
    end else if (idx == `TMCI_IDX_CMP_B) begin
      reg_sel = tmci_pkg::TMCI_REG_CMP_B;
    end else begin
      reg_sel = tmci_pkg::TMCI_REG_NONE;
    end
  endfunction : reg_sel

  // three irq bits placed at their register positions
  function automatic logic [7:0] irq_bits(input logic [2:0] v);
    irq_bits = `TMCI_RESET_8;
    irq_bits[`TMCI_BIT_MATCH_A]  = v[2];
    irq_bits[`TMCI_BIT_MATCH_B]  = v[1];
    irq_bits[`TMCI_BIT_OVERFLOW] = v[0];
  endfunction : irq_bits

  // next waveform output for one channel
  function automatic logic wave_next(
    input logic [1:0] act,
    input logic       cur,
    input logic       pc,
    input logic       fast,
    input logic       may_toggle,
    input logic       down,
    input logic       match,
    input logic       bottom
  );
    wave_next = cur;
    if (!pc && !fast) begin
      if (match) begin
        case (act)
          2'h1: wave_next = ~cur;
          2'h2: wave_next = 1'b0;
          2'h3: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
    end else if (fast) begin
      if (match) begin
        case (act)
          2'h1: wave_next = may_toggle ? ~cur : cur;
          2'h2: wave_next = 1'b0;
          2'h3: wave_next = 1'b1;
          default: wave_next = cur;
        endcase
      end
      // bottom comes last so a match at top is overridden
      if (bottom && act[1]) begin
        wave_next = ~act[0];
      end
    end else if (match) begin
      case (act)
        2'h1: wave_next = may_toggle ? ~cur : cur;
        2'h2: wave_next = down;
        2'h3: wave_next = ~down;
        default: wave_next = cur;
      endcase
    end
  endfunction : wave_next

  logic [2:0]           wgm;
  logic                 is_pc;
  logic                 is_fast;
  logic                 non_pwm;
  logic                 top_is_cmp;
  logic [7:0]           top;
  logic                 tick;
  logic                 at_top;
  logic                 match_a;
  logic                 match_b;
  logic                 ovf;
  logic                 wrap;
  logic                 wr_go;
  logic [7:0]           wd;
  logic [2:0]           clr;
  logic [2:0]           set;
  tmci_pkg::tmci_reg_e  wsel;
  tmci_pkg::tmci_reg_e  rsel;
  logic [7:0]           rval;

  always_comb begin
    st_nxt = st_r;

    // mode decode
    wgm        = {st_r.wgm_high, st_r.ctrl_a[`TMCI_CA_WGM_HI:`TMCI_CA_WGM_LO]};
    is_pc      = (wgm == tmci_pkg::TMCI_WGM_PC_FF) || (wgm == tmci_pkg::TMCI_WGM_PC_OCR);
    is_fast    = (wgm == tmci_pkg::TMCI_WGM_FAST_FF) || (wgm == tmci_pkg::TMCI_WGM_FAST_OCR);
    non_pwm    = !is_pc && !is_fast;
    top_is_cmp = (wgm == tmci_pkg::TMCI_WGM_CTC) || (wgm == tmci_pkg::TMCI_WGM_PC_OCR)
                 || (wgm == tmci_pkg::TMCI_WGM_FAST_OCR);
    top        = top_is_cmp ? st_r.cmp_a : `TMCI_MAX;

    // count pin synchroniser and prescaler
    st_nxt.ext_s1 = ext_count_pin;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;
    st_nxt.pre    = st_r.pre + `TMCI_PRE_W'(1);
    case (tmci_pkg::tmci_cs_e'(st_r.cs))
      tmci_pkg::TMCI_CS_DIV1:     tick = 1'b1;
      tmci_pkg::TMCI_CS_DIV8:     tick = (st_r.pre & `TMCI_PRE_DIV8) == `TMCI_PRE_DIV8;
      tmci_pkg::TMCI_CS_DIV64:    tick = (st_r.pre & `TMCI_PRE_DIV64) == `TMCI_PRE_DIV64;
      tmci_pkg::TMCI_CS_DIV256:   tick = (st_r.pre & `TMCI_PRE_DIV256) == `TMCI_PRE_DIV256;
      tmci_pkg::TMCI_CS_DIV1024:  tick = (st_r.pre & `TMCI_PRE_DIV1024) == `TMCI_PRE_DIV1024;
      tmci_pkg::TMCI_CS_EXT_FALL: tick = st_r.ext_s3 && !st_r.ext_s2;
      tmci_pkg::TMCI_CS_EXT_RISE: tick = !st_r.ext_s3 && st_r.ext_s2;
      default:                    tick = 1'b0;
    endcase

    // counting, compare and overflow on a timer tick
    at_top  = st_r.cnt == top;
    match_a = tick && !st_r.block && (st_r.cnt == st_r.cmp_a);
    match_b = tick && !st_r.block && (st_r.cnt == st_r.cmp_b);
    wrap    = tick && is_fast && at_top;
    if (is_pc) begin
      ovf = tick && (st_r.cnt == `TMCI_BOTTOM);
    end else if (wgm == tmci_pkg::TMCI_WGM_FAST_OCR) begin
      ovf = tick && at_top;
    end else begin
      ovf = tick && (st_r.cnt == `TMCI_MAX);
    end

    if (tick) begin
      st_nxt.block = 1'b0;
      if (is_pc) begin
        if (!st_r.down && at_top) begin
          st_nxt.down = 1'b1;
          st_nxt.cnt  = (top == `TMCI_BOTTOM) ? st_r.cnt : st_r.cnt - `TMCI_ONE;
        end else if (st_r.down && st_r.cnt == `TMCI_BOTTOM) begin
          st_nxt.down = 1'b0;
          st_nxt.cnt  = st_r.cnt + `TMCI_ONE;
        end else begin
          st_nxt.cnt  = st_r.down ? st_r.cnt - `TMCI_ONE : st_r.cnt + `TMCI_ONE;
        end
      end else begin
        st_nxt.down = 1'b0;
        st_nxt.cnt  = at_top ? `TMCI_BOTTOM : st_r.cnt + `TMCI_ONE;
      end
    end

    // compare buffer transfer
    if (non_pwm || (tick && at_top && (is_pc || is_fast))) begin
      st_nxt.cmp_a = st_r.cmp_a_buf;
      st_nxt.cmp_b = st_r.cmp_b_buf;
    end

    // waveform outputs
    st_nxt.out_a = wave_next(st_r.ctrl_a[`TMCI_CA_ACT_A_HI:`TMCI_CA_ACT_A_LO], st_r.out_a, is_pc,
                             is_fast, st_r.wgm_high, st_r.down, match_a, wrap);
    st_nxt.out_b = wave_next(st_r.ctrl_a[`TMCI_CA_ACT_B_HI:`TMCI_CA_ACT_B_LO], st_r.out_b, is_pc,
                             is_fast, 1'b0, st_r.down, match_b, wrap);
    st_nxt.con_a = st_r.ctrl_a[`TMCI_CA_ACT_A_HI:`TMCI_CA_ACT_A_LO] != 2'h0;
    st_nxt.con_b = st_r.ctrl_a[`TMCI_CA_ACT_B_HI:`TMCI_CA_ACT_B_LO] != 2'h0;

    set = {match_a, match_b, ovf};
    clr = {ack_match_a, ack_match_b, ack_overflow};

    // write channel: address and data taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_held = 1'b1;
      st_nxt.waddr   = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_held = 1'b1;
      st_nxt.wdata  = s_axi_wdata[7:0];
      st_nxt.wlane0 = s_axi_wstrb[0];
    end
    wr_go = st_r.aw_held && st_r.w_held && !st_r.bvalid;
    wsel  = reg_sel(st_r.waddr);
    wd    = st_r.wdata;
    if (s_axi_bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_nxt.aw_held = 1'b0;
      st_nxt.w_held  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = (wsel == tmci_pkg::TMCI_REG_NONE) ? `TMCI_RESP_SLVERR : `TMCI_RESP_OKAY;
      if (st_r.wlane0) begin
        if (wsel == tmci_pkg::TMCI_REG_CTRL_A) begin
          st_nxt.ctrl_a = {wd[`TMCI_CA_ACT_A_HI:`TMCI_CA_ACT_B_LO], 4'h0} |
                          {6'h00, wd[`TMCI_CA_WGM_HI:`TMCI_CA_WGM_LO]};
        end else if (wsel == tmci_pkg::TMCI_REG_CTRL_B) begin
          st_nxt.wgm_high = wd[`TMCI_CB_WGM_HIGH];
          st_nxt.cs       = wd[`TMCI_CB_CS_HI:`TMCI_CB_CS_LO];
          // strobes act on the mode and action in force now
          if (non_pwm && wd[`TMCI_CB_FORCE_A]) begin
            st_nxt.out_a = wave_next(st_r.ctrl_a[`TMCI_CA_ACT_A_HI:`TMCI_CA_ACT_A_LO], st_r.out_a,
                                     1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
          end
          if (non_pwm && wd[`TMCI_CB_FORCE_B]) begin
            st_nxt.out_b = wave_next(st_r.ctrl_a[`TMCI_CA_ACT_B_HI:`TMCI_CA_ACT_B_LO], st_r.out_b,
                                     1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
          end
        end else if (wsel == tmci_pkg::TMCI_REG_FLAGS) begin
          clr = clr | {wd[`TMCI_BIT_MATCH_A], wd[`TMCI_BIT_MATCH_B], wd[`TMCI_BIT_OVERFLOW]};
        end else if (wsel == tmci_pkg::TMCI_REG_MASK) begin
          st_nxt.mask = {wd[`TMCI_BIT_MATCH_A], wd[`TMCI_BIT_MATCH_B], wd[`TMCI_BIT_OVERFLOW]};
        end else if (wsel == tmci_pkg::TMCI_REG_COUNTER) begin
          st_nxt.cnt   = wd;
          st_nxt.block = 1'b1;
        end else if (wsel == tmci_pkg::TMCI_REG_CMP_A) begin
          st_nxt.cmp_a_buf = wd;
        end else if (wsel == tmci_pkg::TMCI_REG_CMP_B) begin
          st_nxt.cmp_b_buf = wd;
        end
      end
    end
    st_nxt.flags   = (st_r.flags & ~clr) | set;
    st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

    // read channel
    rsel = reg_sel(s_axi_araddr);
    if (rsel == tmci_pkg::TMCI_REG_CTRL_A) begin
      rval = st_r.ctrl_a;
    end else if (rsel == tmci_pkg::TMCI_REG_CTRL_B) begin
      rval = {4'h0, st_r.wgm_high, st_r.cs};
    end else if (rsel == tmci_pkg::TMCI_REG_FLAGS) begin
      rval = irq_bits(st_r.flags);
    end else if (rsel == tmci_pkg::TMCI_REG_MASK) begin
      rval = irq_bits(st_r.mask);
    end else if (rsel == tmci_pkg::TMCI_REG_COUNTER) begin
      rval = st_r.cnt;
    end else if (rsel == tmci_pkg::TMCI_REG_CMP_A) begin
      rval = st_r.cmp_a_buf;
    end else if (rsel == tmci_pkg::TMCI_REG_CMP_B) begin
      rval = st_r.cmp_b_buf;
    end else begin
      rval = `TMCI_RESET_8;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = {24'h000000, rval};
      st_nxt.rresp  = (rsel == tmci_pkg::TMCI_REG_NONE) ? `TMCI_RESP_SLVERR : `TMCI_RESP_OKAY;
    end
    st_nxt.arready = !st_nxt.rvalid;

    st_nxt.irq = st_r.flags & st_r.mask & {3{global_irq_en}};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready        = st_r.awready;
  assign s_axi_wready         = st_r.wready;
  assign s_axi_bresp          = st_r.bresp;
  assign s_axi_bvalid         = st_r.bvalid;
  assign s_axi_arready        = st_r.arready;
  assign s_axi_rdata          = st_r.rdata;
  assign s_axi_rresp          = st_r.rresp;
  assign s_axi_rvalid         = st_r.rvalid;
  assign wave_out_a           = st_r.out_a;
  assign wave_out_b           = st_r.out_b;
  assign wave_out_a_connected = st_r.con_a;
  assign wave_out_b_connected = st_r.con_b;
  assign irq_match_a          = st_r.irq[2];
  assign irq_match_b          = st_r.irq[1];
  assign irq_overflow         = st_r.irq[0];

endmodule : tmci_timer0

// ---- tmci_timer0_properties.sv ----
/*
  Checker for the timer block: bus answer timing, reserved read bits,
  interrupt request gating.
  Assumes it is bound into tmci_timer0 and sees only its ports.
*/
`timescale 1ns/1ps
`include "tmci_defines.svh"
module tmci_timer0_properties (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic [`TMCI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  input wire logic                    global_irq_en,
  input wire logic                    irq_match_a,
  input wire logic                    irq_match_b,
  input wire logic                    irq_overflow
);
  // address of the read now answered
  logic [9:0] ra_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) ra_r <= 10'h000;
    else if (s_axi_arvalid && s_axi_arready) ra_r <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_wr_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  property p_r_once; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_r_once: assert property (p_r_once) else $error("read answer repeated");
  property p_unm; s_axi_rvalid && ra_r == 10'h3FC |-> s_axi_rresp == `TMCI_RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not refused");
  property p_rsv_a; s_axi_rvalid && ra_r == {`TMCI_IDX_CTRL_A, 2'h0} |-> (s_axi_rdata & 32'hFFFFFF0C) == 32'h0; endproperty
  a_rsv_a: assert property (p_rsv_a) else $error("control a reserved bits set");
  property p_rsv_f; s_axi_rvalid && (ra_r == {`TMCI_IDX_FLAGS, 2'h0} || ra_r == {`TMCI_IDX_MASK, 2'h0})
    |-> (s_axi_rdata & 32'hFFFFFFE5) == 32'h0; endproperty
  a_rsv_f: assert property (p_rsv_f) else $error("flag or mask reserved bits set");
  property p_foc; s_axi_rvalid && ra_r == {`TMCI_IDX_CTRL_B, 2'h0} |-> (s_axi_rdata & 32'hFFFFFFF0) == 32'h0; endproperty
  a_foc: assert property (p_foc) else $error("control b upper bits set");
  property p_irq_a; irq_match_a |-> $past(global_irq_en); endproperty
  a_irq_a: assert property (p_irq_a) else $error("match a request without enable");
  property p_irq_b; irq_match_b |-> $past(global_irq_en); endproperty
  a_irq_b: assert property (p_irq_b) else $error("match b request without enable");
  property p_irq_o; irq_overflow |-> $past(global_irq_en); endproperty
  a_irq_o: assert property (p_irq_o) else $error("overflow request without enable");
endmodule : tmci_timer0_properties
bind tmci_timer0 tmci_timer0_properties tmci_timer0_properties_inst (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .global_irq_en, .irq_match_a, .irq_match_b, .irq_overflow);

// ---- tmci_tb.sv ----
/*
  Bench for the timer block: bus tasks and one task per scenario.
  Assumes design and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "tmci_defines.svh"
module tb;
  logic        aclk, aresetn, ext_count_pin, global_irq_en, ack_match_a, ack_match_b, ack_overflow;
  logic [9:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        wave_out_a, wave_out_b, wave_out_a_connected, wave_out_b_connected;
  logic        irq_match_a, irq_match_b, irq_overflow;
  int          n_mismatch, checks_done, cyc;
  localparam logic [9:0] ad_ca = {`TMCI_IDX_CTRL_A, 2'h0};
  localparam logic [9:0] ad_cb = {`TMCI_IDX_CTRL_B, 2'h0};
  localparam logic [9:0] ad_fl = {`TMCI_IDX_FLAGS, 2'h0};
  localparam logic [9:0] ad_mk = {`TMCI_IDX_MASK, 2'h0};
  localparam logic [9:0] ad_cn = {`TMCI_IDX_COUNTER, 2'h0};
  localparam logic [9:0] ad_oa = {`TMCI_IDX_CMP_A, 2'h0};
  localparam logic [9:0] ad_ob = {`TMCI_IDX_CMP_B, 2'h0};
  localparam logic [9:0] regs [7] = '{ad_ca, ad_cb, ad_fl, ad_mk, ad_cn, ad_oa, ad_ob};
  localparam int         divs [4] = '{8, 64, 256, 1024};
  tmci_timer0 tmci_timer0_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_count_pin,
    .global_irq_en, .ack_match_a, .ack_match_b, .ack_overflow, .wave_out_a, .wave_out_b, .wave_out_a_connected,
    .wave_out_b_connected, .irq_match_a, .irq_match_b, .irq_overflow);
  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // bready and rready held high
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rr = s_axi_rresp;
  endtask : rd
  task automatic rchk(input logic [9:0] a, input logic [31:0] e, input string nm);
    rd(a, rd_v);
    chk(nm, rd_v, e);
  endtask : rchk
  task automatic pulse(input logic [2:0] v);
    {ack_match_a, ack_match_b, ack_overflow} <= v;
    @(posedge aclk);
    {ack_match_a, ack_match_b, ack_overflow} <= 3'h0;
    @(posedge aclk);
  endtask : pulse
  task automatic t_reset();
    foreach (regs[i]) rchk(regs[i], 32'h0, "reset value");
    rd(10'h3FC, rd_v);
    chk("unmapped rresp", {30'h0, rr}, 32'h2);
    wr(10'h3FC, 8'hFF);
    chk("unmapped bresp", {30'h0, rs}, 32'h2);
  endtask : t_reset
  task automatic t_bits();
    wr(ad_ca, 8'hFF);
    rchk(ad_ca, 32'hF3, "ctrl a");
    wr(ad_ca, 8'h00);
    wr(ad_cb, 8'hF8);
    rchk(ad_cb, 32'h08, "ctrl b");
    wr(ad_cb, 8'h00);
    wr(ad_mk, 8'hFF);
    rchk(ad_mk, 32'h1A, "mask");
    wr(ad_mk, 8'h00);
    wr(ad_cn, 8'hA5);
    wr(ad_oa, 8'h5A);
    s_axi_wstrb <= 4'h0;
    wr(ad_cn, 8'h11);
    s_axi_wstrb <= 4'hF;
    rchk(ad_cn, 32'hA5, "count");
    rchk(ad_oa, 32'h5A, "compare a");
  endtask : t_bits
  task automatic t_force();
    logic [1:0] act [4];
    logic       ex [4];
    act = '{2'h3, 2'h2, 2'h1, 2'h1};
    ex = '{1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(ad_ca, {act[i], act[i], 4'h2});
      wr(ad_cb, 8'hC0);
      chk("out a", wave_out_a, ex[i]);
      chk("out b", wave_out_b, ex[i]);
    end
    chk("out a on", wave_out_a_connected, 32'h1);
    rchk(ad_fl, 32'h0, "flags after force");
    rchk(ad_cn, 32'hA5, "count after force");
    wr(ad_ca, 8'hF1);
    wr(ad_cb, 8'hC0);
    chk("out a pwm", wave_out_a, 32'h0);
    wr(ad_ca, 8'h00);
    @(posedge aclk);
    chk("out b off", wave_out_b_connected, 32'h0);
  endtask : t_force
  task automatic run_mode(input logic [2:0] m, input logic [7:0] ca, cb, c0, input int n, input logic [7:0] e);
    wr(ad_cb, 8'h00);
    wr(ad_ca, 8'h00);
    wr(ad_oa, ca);
    wr(ad_ob, cb);
    wr(ad_cn, c0);
    wr(ad_fl, 8'hFF);
    wr(ad_ca, {6'h00, m[1:0]});
    wr(ad_cb, {4'h0, m[2], 3'h1});
    repeat (n) @(posedge aclk);
    wr(ad_cb, {4'h0, m[2], 3'h0});
    rchk(ad_fl, {24'h0, e}, "flags");
  endtask : run_mode
  task automatic t_modes();
    run_mode(3'h2, 8'h04, 8'h02, 8'h00, 20, 8'h18);
    rd(ad_cn, rd_v);
    chk("clear on match top", rd_v <= 32'h4, 32'h1);
    run_mode(3'h3, 8'h80, 8'hFD, 8'hFD, 10, 8'h02);
    run_mode(3'h4, 8'h80, 8'h80, 8'hFD, 10, 8'h02);
    run_mode(3'h6, 8'h80, 8'h80, 8'hFD, 10, 8'h02);
    run_mode(3'h1, 8'h80, 8'h80, 8'hFC, 10, 8'h00);
    run_mode(3'h5, 8'h08, 8'h80, 8'h04, 30, 8'h12);
    run_mode(3'h7, 8'h10, 8'h80, 8'h0C, 20, 8'h12);
  endtask : t_modes
  task automatic t_irq();
    run_mode(3'h2, 8'h04, 8'h02, 8'h00, 20, 8'h18);
    wr(ad_mk, 8'h1A);
    repeat (3) @(posedge aclk);
    chk("irq a masked by global", irq_match_a, 32'h0);
    global_irq_en <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("irq a", irq_match_a, 32'h1);
    chk("irq b", irq_match_b, 32'h1);
    chk("irq ovf", irq_overflow, 32'h0);
    wr(ad_fl, 8'h08);
    rchk(ad_fl, 32'h10, "flags w1c");
    pulse(3'h4);
    rchk(ad_fl, 32'h0, "flags ack a");
    run_mode(3'h0, 8'h80, 8'h80, 8'hFD, 10, 8'h02);
    repeat (3) @(posedge aclk);
    chk("irq ovf", irq_overflow, 32'h1);
    pulse(3'h7);
    rchk(ad_fl, 32'h0, "flags ack ovf");
    global_irq_en <= 1'b0;
    wr(ad_mk, 8'h00);
  endtask : t_irq
  task automatic t_clk();
    for (int s = 2; s <= 5; s++) begin
      wr(ad_cn, 8'h00);
      wr(ad_cb, {5'h00, s[2:0]});
      repeat (4 * divs[s-2]) @(posedge aclk);
      wr(ad_cb, 8'h00);
      rd(ad_cn, rd_v);
      chk("prescaled count", rd_v >= 32'h3 && rd_v <= 32'h5, 32'h1);
    end
    wr(ad_cn, 8'h33);
    repeat (20) @(posedge aclk);
    rchk(ad_cn, 32'h33, "stopped count");
  endtask : t_clk
  task automatic t_ext(input logic [2:0] cs);
    wr(ad_cn, 8'h00);
    wr(ad_cb, {5'h00, cs});
    repeat (5) begin
      ext_count_pin <= 1'b1;
      repeat (4) @(posedge aclk);
      ext_count_pin <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    repeat (8) @(posedge aclk);
    wr(ad_cb, 8'h00);
    rchk(ad_cn, 32'h5, "pin edges");
  endtask : t_ext
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, ext_count_pin, global_irq_en} = 5'h00;
    {ack_match_a, ack_match_b, ack_overflow} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 52'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_bits();
    t_force();
    t_modes();
    t_irq();
    t_clk();
    t_ext(3'h7);
    t_ext(3'h6);
    summarize();
  end
endmodule : tb
